//--- src/tcpwm_pkg.sv
// Contract
// R1 - clock B divide select bits 6..4, 1..128
// R2 - clock A select bits 2..0, channel 0 only
// R3 - decode at blocking and non-blocking bases
// R4 - disabled writes update buffer and active together
// R5 - enabled updates only at load point
// R6 - 8-bit counter advances at selected rate
// R7 - duty match toggles the output flip-flop
// R8 - counter reads never disturb counting
// R9 - counter write clears, reloads, restarts output
// R10 - disable halts counter, enable resumes
// R11 - disabled zero period resets counter next tick
// R12 - enabled counter write restarts period immediately
// R13 - counter cleared when effective period ends
// R14 - polarity picks high or low duty time
// R15 - align clear means left-aligned up count
// R16 - period match resets counter, output, reloads
// R17 - left-aligned counts 0 to period minus one
// R18 - software writes counter before enabling channel
// R19 - clock-select bit picks between two sources
// R20 - align set gives centre-aligned output
// R21 - clock A uses clock B encoding
// R22 - reset clears counters, enables, prescale selects
package tcpwm_pkg;

  // ----------------------------------------------------------------
  // bus and address map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam logic [9:0] BASE_BLOCK_IDX = 10'h200;
  localparam logic [9:0] BASE_NONBLK_IDX = 10'h300;
  localparam logic [9:0] WINDOW_IDX = 10'h100;
  localparam logic [7:0] PRESCALE_IDX = 8'h61;
  localparam logic [7:0] CTRL_IDX = 8'h62;
  localparam logic [7:0] CNT0_IDX = 8'h63;
  localparam logic [7:0] CNT1_IDX = 8'h64;
  localparam logic [7:0] PER0_IDX = 8'h65;
  localparam logic [7:0] PER1_IDX = 8'h66;
  localparam logic [7:0] DUTY0_IDX = 8'h67;
  localparam logic [7:0] DUTY1_IDX = 8'h68;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CLKA_LSB = 0;
  localparam int unsigned CLKB_LSB = 4;
  localparam int unsigned EN_LSB = 0;
  localparam int unsigned POL_LSB = 2;
  localparam int unsigned ALIGN_LSB = 4;
  localparam int unsigned CHOICE_LSB = 6;
  localparam logic [7:0] PRESCALE_MASK = 8'h77;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam int unsigned DIV_W = 7;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_PRESCALE, SEL_CTRL, SEL_CNT0, SEL_CNT1,
    SEL_PER0, SEL_PER1, SEL_DUTY0, SEL_DUTY1
  } tcpwm_sel_e;

  typedef struct packed {
    logic en;
    logic pol;
    logic align;
    logic choice;
  } tcpwm_cfg_s;

endpackage

//--- src/tcpwm_top.sv
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module tcpwm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tcpwm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [tcpwm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // waveform outputs
  output logic [1:0] pwm_out
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic tcpwm_pkg::tcpwm_sel_e reg_decode(
    input logic [tcpwm_pkg::ADDR_W-1:0] addr
  );
    logic [9:0] idx;
    logic [9:0] rel;
    logic hit;
    idx = addr[tcpwm_pkg::ADDR_W-1:2];
    hit = 1'b0;
    rel = idx - tcpwm_pkg::BASE_BLOCK_IDX;
    if (idx >= tcpwm_pkg::BASE_BLOCK_IDX &&
        rel < tcpwm_pkg::WINDOW_IDX)
      hit = 1'b1; // [R3]
    if (idx >= tcpwm_pkg::BASE_NONBLK_IDX &&
        idx - tcpwm_pkg::BASE_NONBLK_IDX < tcpwm_pkg::WINDOW_IDX)
    begin
      hit = 1'b1; // [R3]
      rel = idx - tcpwm_pkg::BASE_NONBLK_IDX;
    end
    reg_decode = tcpwm_pkg::SEL_NONE;
    if (hit)
    begin
      unique case (rel[7:0])
        tcpwm_pkg::PRESCALE_IDX: reg_decode = tcpwm_pkg::SEL_PRESCALE;
        tcpwm_pkg::CTRL_IDX: reg_decode = tcpwm_pkg::SEL_CTRL;
        tcpwm_pkg::CNT0_IDX: reg_decode = tcpwm_pkg::SEL_CNT0;
        tcpwm_pkg::CNT1_IDX: reg_decode = tcpwm_pkg::SEL_CNT1;
        tcpwm_pkg::PER0_IDX: reg_decode = tcpwm_pkg::SEL_PER0;
        tcpwm_pkg::PER1_IDX: reg_decode = tcpwm_pkg::SEL_PER1;
        tcpwm_pkg::DUTY0_IDX: reg_decode = tcpwm_pkg::SEL_DUTY0;
        tcpwm_pkg::DUTY1_IDX: reg_decode = tcpwm_pkg::SEL_DUTY1;
        default: reg_decode = tcpwm_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // divided clock tick: select n gives one tick every 2**n cycles
  function automatic logic div_tick(
    input logic [tcpwm_pkg::DIV_W-1:0] cnt,
    input logic [2:0] sel
  );
    logic [tcpwm_pkg::DIV_W-1:0] mask;
    mask = tcpwm_pkg::DIV_W'((8'h01 << sel) - 8'h01);
    div_tick = ((cnt & mask) == mask);
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic aw_taken_q;
  logic w_taken_q;
  logic [tcpwm_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;

  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs = s_axi_wvalid & wready_q;
  wire b_hs = bvalid_q & s_axi_bready;
  wire ar_hs = s_axi_arvalid & arready_q;
  wire r_hs = rvalid_q & s_axi_rready;
  wire aw_taken_d = b_hs ? 1'b0 : (aw_hs | aw_taken_q);
  wire w_taken_d = b_hs ? 1'b0 : (w_hs | w_taken_q);
  wire wr_fire = aw_taken_q & w_taken_q & ~bvalid_q;
  wire rvalid_d = r_hs ? 1'b0 : (ar_hs | rvalid_q);
  tcpwm_pkg::tcpwm_sel_e wsel;
  tcpwm_pkg::tcpwm_sel_e rsel;
  assign wsel = reg_decode(awaddr_q);
  assign rsel = reg_decode(s_axi_araddr);
  wire wr_en = wr_fire & wstrb0_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_taken_q <= 1'b0;
      w_taken_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= tcpwm_pkg::BYTE_ZERO;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      aw_taken_q <= aw_taken_d;
      w_taken_q <= w_taken_d;
      awready_q <= ~aw_taken_d;
      wready_q <= ~w_taken_d;
      if (aw_hs)
        awaddr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= tcpwm_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel == tcpwm_pkg::SEL_NONE) ?
                 tcpwm_pkg::RESP_SLVERR : tcpwm_pkg::RESP_OKAY;
    end
    else if (b_hs)
      bvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] prescale_q;
  logic [7:0] ctrl_q;
  logic [tcpwm_pkg::DIV_W-1:0] div_q;
  tcpwm_pkg::tcpwm_cfg_s cfg [2];
  logic [7:0] cnt_rd [2];
  logic [7:0] per_rd [2];
  logic [7:0] duty_rd [2];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_q <= tcpwm_pkg::PRESCALE_RST; // [R22]
      ctrl_q <= tcpwm_pkg::CTRL_RST; // [R22]
    end
    else
    begin
      if (wr_en && wsel == tcpwm_pkg::SEL_PRESCALE)
        prescale_q <= wdata_q & tcpwm_pkg::PRESCALE_MASK;
      if (wr_en && wsel == tcpwm_pkg::SEL_CTRL)
        ctrl_q <= wdata_q; // [R19]
    end
  end

  // free-running prescaler shared by clock a and clock b
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  wire tick_a = div_tick(div_q,
    prescale_q[tcpwm_pkg::CLKA_LSB +: 3]); // [R2] [R21]
  wire tick_b = div_tick(div_q,
    prescale_q[tcpwm_pkg::CLKB_LSB +: 3]); // [R1]

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rmux;
  always_comb
  begin
    rmux = tcpwm_pkg::BYTE_ZERO;
    unique case (rsel)
      tcpwm_pkg::SEL_PRESCALE: rmux = prescale_q;
      tcpwm_pkg::SEL_CTRL: rmux = ctrl_q;
      tcpwm_pkg::SEL_CNT0: rmux = cnt_rd[0]; // [R8]
      tcpwm_pkg::SEL_CNT1: rmux = cnt_rd[1]; // [R8]
      tcpwm_pkg::SEL_PER0: rmux = per_rd[0];
      tcpwm_pkg::SEL_PER1: rmux = per_rd[1];
      tcpwm_pkg::SEL_DUTY0: rmux = duty_rd[0];
      tcpwm_pkg::SEL_DUTY1: rmux = duty_rd[1];
      tcpwm_pkg::SEL_NONE: rmux = tcpwm_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= tcpwm_pkg::BYTE_ZERO;
      rresp_q <= tcpwm_pkg::RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_hs)
      begin
        rdata_q <= rmux;
        rresp_q <= (rsel == tcpwm_pkg::SEL_NONE) ?
                   tcpwm_pkg::RESP_SLVERR : tcpwm_pkg::RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [1:0] pin_q;

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic dir_q;
    logic dir_d;
    logic ff_q;
    logic ff_d;
    logic [7:0] per_buf_q;
    logic [7:0] duty_buf_q;
    logic [7:0] per_act_q;
    logic [7:0] duty_act_q;
    logic load;
    logic zero_pend_q;

    assign cfg[i] = '{
      en: ctrl_q[tcpwm_pkg::EN_LSB + i],
      pol: ctrl_q[tcpwm_pkg::POL_LSB + i],
      align: ctrl_q[tcpwm_pkg::ALIGN_LSB + i],
      choice: ctrl_q[tcpwm_pkg::CHOICE_LSB + i]
    };
    wire src_tick = cfg[i].choice ? 1'b1 :
                    ((i == 0) ? tick_a : tick_b); // [R2] [R19]
    wire run = src_tick & cfg[i].en; // [R6] [R10]
    wire wr_cnt = wr_en && (wsel == ((i == 0) ?
                  tcpwm_pkg::SEL_CNT0 : tcpwm_pkg::SEL_CNT1));
    wire wr_per = wr_en && (wsel == ((i == 0) ?
                  tcpwm_pkg::SEL_PER0 : tcpwm_pkg::SEL_PER1));
    wire wr_duty = wr_en && (wsel == ((i == 0) ?
                   tcpwm_pkg::SEL_DUTY0 : tcpwm_pkg::SEL_DUTY1));
    wire [7:0] cnt_inc = cnt_q + tcpwm_pkg::BYTE_ONE;
    wire [7:0] cnt_dec = cnt_q - tcpwm_pkg::BYTE_ONE;

    always_comb
    begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      ff_d = ff_q;
      load = 1'b0;
      if (wr_cnt)
      begin
        cnt_d = tcpwm_pkg::BYTE_ZERO; // [R9] [R12]
        dir_d = 1'b0;
        load = 1'b1;
      end
      else if (run && !cfg[i].align)
      begin
        if (cnt_inc >= per_act_q || per_act_q == tcpwm_pkg::BYTE_ZERO)
        begin
          cnt_d = tcpwm_pkg::BYTE_ZERO; // [R13] [R16] [R17]
          load = 1'b1; // [R5] [R16]
        end
        else
        begin
          cnt_d = cnt_inc; // [R15]
          if (cnt_d == duty_act_q)
            ff_d = ~ff_q; // [R7]
        end
      end
      else if (run)
      begin
        if (per_act_q == tcpwm_pkg::BYTE_ZERO)
          cnt_d = tcpwm_pkg::BYTE_ZERO;
        else if (!dir_q && cnt_q >= per_act_q)
        begin
          dir_d = 1'b1; // [R20]
          cnt_d = cnt_dec;
        end
        else if (!dir_q)
          cnt_d = cnt_inc;
        else if (cnt_q <= tcpwm_pkg::BYTE_ONE)
        begin
          cnt_d = tcpwm_pkg::BYTE_ZERO; // [R13]
          dir_d = 1'b0;
          load = 1'b1; // [R5]
        end
        else
          cnt_d = cnt_dec;
        if (!load && cnt_d == duty_act_q)
          ff_d = ~ff_q; // [R7]
      end
      else if (src_tick && zero_pend_q)
        cnt_d = tcpwm_pkg::BYTE_ZERO; // [R11]
      if (load)
        ff_d = (duty_buf_q == tcpwm_pkg::BYTE_ZERO);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_q <= tcpwm_pkg::BYTE_ZERO; // [R22]
        dir_q <= 1'b0;
        ff_q <= 1'b0;
        zero_pend_q <= 1'b0;
      end
      else
      begin
        cnt_q <= cnt_d;
        dir_q <= dir_d;
        ff_q <= ff_d;
        if (wr_per && !cfg[i].en && wdata_q == tcpwm_pkg::BYTE_ZERO)
          zero_pend_q <= 1'b1; // [R11]
        else if (src_tick || cfg[i].en)
          zero_pend_q <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        per_buf_q <= tcpwm_pkg::BYTE_ZERO;
        duty_buf_q <= tcpwm_pkg::BYTE_ZERO;
        per_act_q <= tcpwm_pkg::BYTE_ZERO;
        duty_act_q <= tcpwm_pkg::BYTE_ZERO;
      end
      else
      begin
        if (wr_per)
          per_buf_q <= wdata_q;
        if (wr_duty)
          duty_buf_q <= wdata_q;
        if (load)
        begin
          per_act_q <= per_buf_q; // [R5] [R9] [R16]
          duty_act_q <= duty_buf_q;
        end
        if (wr_per && !cfg[i].en)
          per_act_q <= wdata_q; // [R4]
        if (wr_duty && !cfg[i].en)
          duty_act_q <= wdata_q; // [R4]
      end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        pin_q[i] <= 1'b0;
      else
        pin_q[i] <= cfg[i].pol ^ ff_d; // [R14]
    end

    assign cnt_rd[i] = cnt_q;
    assign per_rd[i] = per_buf_q;
    assign duty_rd[i] = duty_buf_q;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;
  assign pwm_out = pin_q;

endmodule
`default_nettype wire

//--- tb/tcpwm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus-side checks
// ----------------------------------------
module tcpwm_top_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  function automatic logic hit(input logic [11:0] a);
    logic [9:0] i;
    logic [9:0] j;
    i = a[11:2] - tcpwm_pkg::BASE_BLOCK_IDX;
    j = a[11:2] - tcpwm_pkg::BASE_NONBLK_IDX;
    return (i >= 10'h061 && i <= 10'h068) || (j >= 10'h061 && j <= 10'h068);
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence

  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_unmapped: assert property (
    s_ar_taken ##0 !hit(s_axi_araddr) |=>
    s_axi_rresp == tcpwm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_mapped: assert property (
    s_ar_taken ##0 hit(s_axi_araddr) |=> s_axi_rresp == tcpwm_pkg::RESP_OKAY)
    else $error("mapped read refused");
  a_write_unmapped: assert property (
    s_aw_taken ##0 !hit(s_axi_awaddr) |->
    ##[1:4] (s_axi_bvalid && s_axi_bresp == tcpwm_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");
  a_write_mapped: assert property (
    s_aw_taken ##0 hit(s_axi_awaddr) |->
    ##[1:4] (s_axi_bvalid && s_axi_bresp == tcpwm_pkg::RESP_OKAY))
    else $error("mapped write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule

bind tcpwm_top tcpwm_top_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
`default_nettype wire

//--- tb/test_two_channel_pwm_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module test_two_channel_pwm_timebase;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, pwm_out, r2;
  int fail_count = 0;
  int checks = 0;
  int n, h;

  tcpwm_top u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pwm_out(pwm_out));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task tmo(input int k);
    if (k >= 5000)
    begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      results();
    end
  endtask

  function automatic logic [11:0] ra(input logic [7:0] i, input logic nb);
    ra = {(nb ? tcpwm_pkg::BASE_NONBLK_IDX : tcpwm_pkg::BASE_BLOCK_IDX)
      + {2'h0, i}, 2'h0};
  endfunction

  task axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && k < 5000);
    tmo(k);
    r = bresp;
    bready <= 1'b0;
  endtask

  task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && k < 5000);
    tmo(k);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    axw(ra(i, 1'b0), d, r2);
  endtask

  task rd(input logic [7:0] i, input logic [31:0] e);
    axr(ra(i, 1'b0), v, r2);
    chk(v, e);
  endtask

  // cycles until the output reaches level lv from the other level
  task lvl(input int ch, input logic lv, output int k);
    logic p, c;
    c = lv;
    k = 0;
    do
    begin
      p = c;
      @(posedge clk);
      c = pwm_out[ch];
      k++;
    end
    while (!(p === ~lv && c === lv) && k < 5000);
    tmo(k);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 8'h61; i <= 8'h68; i++) rd(8'(i), 32'h0);
    axw(ra(tcpwm_pkg::PRESCALE_IDX, 1'b1), 8'hFF, r2);
    chk(32'(r2), 32'(tcpwm_pkg::RESP_OKAY));
    rd(tcpwm_pkg::PRESCALE_IDX, 32'h77);
    axw(12'h980, 8'h11, r2);
    chk(32'(r2), 32'(tcpwm_pkg::RESP_SLVERR));
    axr(12'h980, v, r2);
    chk(v, 32'h0);
    chk(32'(r2), 32'(tcpwm_pkg::RESP_SLVERR));
    wr(tcpwm_pkg::PER0_IDX, 8'h0A);
    wr(tcpwm_pkg::DUTY0_IDX, 8'h04);
    wr(tcpwm_pkg::CNT0_IDX, 8'h55);
    rd(tcpwm_pkg::CNT0_IDX, 32'h0);
    rd(tcpwm_pkg::PER0_IDX, 32'h0A);
    wr(tcpwm_pkg::CTRL_IDX, 8'h45);
    lvl(0, 1'b1, n);
    lvl(0, 1'b0, n);
    chk(32'(n), 32'h4);
    lvl(0, 1'b1, n);
    chk(32'(n), 32'h6);
    axr(ra(tcpwm_pkg::CNT0_IDX, 1'b0), v, r2);
    chk(32'(v < 32'hA), 32'h1);
    wr(tcpwm_pkg::CTRL_IDX, 8'h41);
    lvl(0, 1'b1, n);
    lvl(0, 1'b0, n);
    chk(32'(n), 32'h6);
    wr(tcpwm_pkg::CTRL_IDX, 8'h45);
    wr(tcpwm_pkg::PER0_IDX, 8'h14);
    lvl(0, 1'b1, n);
    lvl(0, 1'b1, n);
    chk(32'(n == 10 || n == 20), 32'h1);
    lvl(0, 1'b1, n);
    chk(32'(n), 32'h14);
    wr(tcpwm_pkg::CNT0_IDX, 8'h00);
    axr(ra(tcpwm_pkg::CNT0_IDX, 1'b0), v, r2);
    chk(32'(v < 32'h8), 32'h1);
    wr(tcpwm_pkg::CTRL_IDX, 8'h00);
    axr(ra(tcpwm_pkg::CNT0_IDX, 1'b0), v, r2);
    h = int'(v);
    repeat (30) @(posedge clk);
    rd(tcpwm_pkg::CNT0_IDX, 32'(h));
    wr(tcpwm_pkg::PER0_IDX, 8'h00);
    // clock a is divided by 128 here: let one selected tick pass
    repeat (130) @(posedge clk);
    rd(tcpwm_pkg::CNT0_IDX, 32'h0);
    wr(tcpwm_pkg::PER0_IDX, 8'h04);
    wr(tcpwm_pkg::PER1_IDX, 8'h04);
    wr(tcpwm_pkg::DUTY0_IDX, 8'h01);
    wr(tcpwm_pkg::DUTY1_IDX, 8'h01);
    wr(tcpwm_pkg::CNT0_IDX, 8'h00);
    wr(tcpwm_pkg::CNT1_IDX, 8'h00);
    wr(tcpwm_pkg::CTRL_IDX, 8'h0F);
    for (int s = 0; s < 8; s++)
    begin
      wr(tcpwm_pkg::PRESCALE_IDX, 8'((s << 4) | (7 - s)));
      lvl(0, 1'b1, n);
      lvl(0, 1'b1, n);
      chk(32'(n), 32'(4 << (7 - s)));
      lvl(1, 1'b1, n);
      lvl(1, 1'b1, n);
      chk(32'(n), 32'(4 << s));
    end
    wr(tcpwm_pkg::CTRL_IDX, 8'h8F);
    lvl(1, 1'b1, n);
    lvl(1, 1'b1, n);
    chk(32'(n), 32'h4);
    wr(tcpwm_pkg::CTRL_IDX, 8'h00);
    wr(tcpwm_pkg::CNT0_IDX, 8'h00);
    wr(tcpwm_pkg::CTRL_IDX, 8'h15);
    lvl(0, 1'b1, n);
    lvl(0, 1'b1, n);
    chk(32'(n), 32'h8);
    results();
  end
endmodule
`default_nettype wire
